//--- mrwf_regs.svh
/*
 * Register offsets, bit positions, reset values and counts of the remote
 * wakeup filter block.
 * Assumes byte addresses on a 12-bit APB address bus with 32-bit data.
 */
`ifndef MRWF_REGS_SVH
`define MRWF_REGS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define MRWF_OFF_FILTER    12'h128
`define MRWF_OFF_CTRL      12'h12C
`define MRWF_OFF_IRQ_STAT  12'h140
`define MRWF_OFF_IRQ_MASK  12'h144
`define MRWF_OFF_OPTION    12'h148

// ----------------------------------------------------------------------
// Control and status bit positions
// ----------------------------------------------------------------------
`define MRWF_BIT_PTR_RST     31
`define MRWF_BIT_GLOBAL_UNICAST_WAKE_ENABLE        9
`define MRWF_BIT_EXACT_SEEN  7
`define MRWF_BIT_SIG_SEEN    5
`define MRWF_BIT_BCAST_SEEN  4
`define MRWF_BIT_EXACT_EN    3
`define MRWF_BIT_FILT_EN     2
`define MRWF_BIT_SIG_EN      1
`define MRWF_BIT_BROADCAST_WAKE_ENABLE    0
`define MRWF_BIT_RES_CLR     0
`define MRWF_SEEN_LSB        4

// ----------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------
`define MRWF_RST_WORD        32'h0000_0000
`define MRWF_FILTER_WORDS    40
`define MRWF_LAST_WORD       6'h27
`define MRWF_NUM_FILTERS     8
`define MRWF_ADDR_BYTES      3'h6
`define MRWF_LAST_ADDR_BYTE  3'h5
`define MRWF_SIG_SYNC        3'h6
`define MRWF_LAST_REPEAT     4'hF
`define MRWF_BCAST_BYTE      8'hFF

`endif

//--- mrwf_pkg.sv
/*
 * Types of the remote wakeup filter block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package mrwf_pkg;

    typedef enum logic [1:0] {
        MRWF_HUNT,
        MRWF_ADDR
    } mrwf_sig_state_t;

    typedef logic [3:0] mrwf_events_t;

endpackage

//--- mrwf_top.sv
/*
 * Remote wakeup filter of the Ethernet MAC: wakeup frame filter memory
 * with auto-advancing pointers, wakeup control and status register,
 * destination-address and wake-signature detection, wake request and
 * interrupt, all reached over APB.
 * Assumes the receive path delivers bytes on pclk, marks first and last
 * byte, and reports frame validity with the last byte; the filter pattern
 * matcher lives outside and reports a hit with the last byte.
 */
`timescale 1ns/1ps
`include "mrwf_regs.svh"

module mrwf_top
    import mrwf_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_valid,
    input wire logic rx_sof,
    input wire logic rx_eof,
    input wire logic [7:0] rx_data,
    input wire logic rx_frame_ok,
    input wire logic filter_hit,
    input wire logic [15:0] station_address_high,
    input wire logic [31:0] station_address_low,
    input wire logic resume_done,
    input wire logic [5:0] filt_rd_idx,
    output logic [31:0] filt_rd_data,
    output logic wake_req,
    output logic irq
);

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    function automatic logic [5:0] next_ptr(input logic [5:0] p);
        next_ptr = (p == `MRWF_LAST_WORD) ? 6'h00 : p + 6'h01;
    endfunction

    // Byte 0 is the first byte on the wire.
    function automatic logic [7:0] addr_byte(input logic [47:0] a,
                                             input logic [2:0] i);
        addr_byte = a[{i, 3'h0} +: 8];
    endfunction

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [31:0] wake_filter_memory [0:`MRWF_FILTER_WORDS-1];
    logic [5:0] wr_ptr_ff;
    logic [5:0] rd_ptr_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] filt_rd_data_ff;
    logic wake_req_ff;
    logic irq_ff;
    logic global_unicast_wake_enable_ff;
    logic exact_address_wake_enable_ff;
    logic filter_frame_wake_enable_ff;
    logic signature_packet_wake_enable_ff;
    logic broadcast_wake_enable_ff;
    logic resume_clears_wake_status_ff;
    mrwf_events_t seen_ff;
    mrwf_events_t nxt_seen;
    mrwf_events_t enables;
    mrwf_events_t events;
    mrwf_events_t irq_stat_ff;
    mrwf_events_t nxt_irq_stat;
    mrwf_events_t irq_mask_ff;
    logic [47:0] station_addr;
    logic acc;
    logic wr_acc;
    logic rd_acc;
    logic hit_filter;
    logic hit_ctrl;
    logic hit_irq_stat;
    logic hit_irq_mask;
    logic hit_option;
    logic mapped;
    logic [31:0] ctrl_word;
    logic [31:0] rd_word;
    logic frame_end;
    logic [6:0] byte_cnt_ff;
    logic [6:0] cur_idx;
    logic in_da;
    logic da_exact_ff;
    logic da_bcast_ff;
    logic da_unicast_ff;
    mrwf_sig_state_t sig_state_ff;
    logic [2:0] ff_cnt_ff;
    logic [2:0] sig_byte_ff;
    logic [3:0] sig_rep_ff;
    logic sig_found_ff;

    assign station_addr = {station_address_high, station_address_low};
    assign enables = {exact_address_wake_enable_ff,
                      filter_frame_wake_enable_ff,
                      signature_packet_wake_enable_ff,
                      broadcast_wake_enable_ff};

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    // Side effects fire once, on the first access-phase edge, when the
    // answer is prepared; pready follows one cycle later.
    assign acc = ce & psel & penable & ~pready_ff;
    assign wr_acc = acc & pwrite;
    assign rd_acc = acc & ~pwrite;
    assign hit_filter = (paddr == `MRWF_OFF_FILTER);
    assign hit_ctrl = (paddr == `MRWF_OFF_CTRL);
    assign hit_irq_stat = (paddr == `MRWF_OFF_IRQ_STAT);
    assign hit_irq_mask = (paddr == `MRWF_OFF_IRQ_MASK);
    assign hit_option = (paddr == `MRWF_OFF_OPTION);
    assign mapped = hit_filter | hit_ctrl | hit_irq_stat | hit_irq_mask
                    | hit_option;

    always_comb
    begin
        ctrl_word = `MRWF_RST_WORD;
        ctrl_word[`MRWF_BIT_GLOBAL_UNICAST_WAKE_ENABLE] = global_unicast_wake_enable_ff;
        ctrl_word[`MRWF_BIT_EXACT_SEEN:`MRWF_SEEN_LSB] = seen_ff;
        ctrl_word[`MRWF_BIT_EXACT_EN:`MRWF_BIT_BROADCAST_WAKE_ENABLE] = enables;
    end

    always_comb
    begin
        rd_word = `MRWF_RST_WORD;
        if (hit_filter)
        begin
            rd_word = wake_filter_memory[rd_ptr_ff];
        end
        else if (hit_ctrl)
        begin
            rd_word = ctrl_word;
        end
        else if (hit_irq_stat)
        begin
            rd_word[3:0] = irq_stat_ff;
        end
        else if (hit_irq_mask)
        begin
            rd_word[3:0] = irq_mask_ff;
        end
        else if (hit_option)
        begin
            rd_word[`MRWF_BIT_RES_CLR] = resume_clears_wake_status_ff;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= `MRWF_RST_WORD;
        end
        else if (ce)
        begin
            pready_ff <= acc;
            pslverr_ff <= acc & ~mapped;
            if (rd_acc)
            begin
                prdata_ff <= rd_word;
            end
        end
    end

    // ------------------------------------------------------------------
    // Filter memory and pointers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < `MRWF_FILTER_WORDS; i++)
            begin
                wake_filter_memory[i] <= `MRWF_RST_WORD;
            end
        end
        else if (wr_acc && hit_filter)
        begin
            wake_filter_memory[wr_ptr_ff] <= pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_ptr_ff <= 6'h00;
        end
        else if (wr_acc && hit_ctrl && pwdata[`MRWF_BIT_PTR_RST])
        begin
            wr_ptr_ff <= 6'h00;
        end
        else if (wr_acc && hit_filter)
        begin
            wr_ptr_ff <= next_ptr(wr_ptr_ff);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rd_ptr_ff <= 6'h00;
        end
        else if (wr_acc && hit_ctrl && pwdata[`MRWF_BIT_PTR_RST])
        begin
            rd_ptr_ff <= 6'h00;
        end
        else if (rd_acc && hit_filter)
        begin
            rd_ptr_ff <= next_ptr(rd_ptr_ff);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            filt_rd_data_ff <= `MRWF_RST_WORD;
        end
        else if (ce)
        begin
            if (filt_rd_idx <= `MRWF_LAST_WORD)
            begin
                filt_rd_data_ff <= wake_filter_memory[filt_rd_idx];
            end
            else
            begin
                filt_rd_data_ff <= `MRWF_RST_WORD;
            end
        end
    end

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            global_unicast_wake_enable_ff <= 1'b0;
            exact_address_wake_enable_ff <= 1'b0;
            filter_frame_wake_enable_ff <= 1'b0;
            signature_packet_wake_enable_ff <= 1'b0;
            broadcast_wake_enable_ff <= 1'b0;
        end
        else if (wr_acc && hit_ctrl)
        begin
            global_unicast_wake_enable_ff <= pwdata[`MRWF_BIT_GLOBAL_UNICAST_WAKE_ENABLE];
            exact_address_wake_enable_ff <= pwdata[`MRWF_BIT_EXACT_EN];
            filter_frame_wake_enable_ff <= pwdata[`MRWF_BIT_FILT_EN];
            signature_packet_wake_enable_ff <= pwdata[`MRWF_BIT_SIG_EN];
            broadcast_wake_enable_ff <= pwdata[`MRWF_BIT_BROADCAST_WAKE_ENABLE];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            resume_clears_wake_status_ff <= 1'b0;
            irq_mask_ff <= 4'h0;
        end
        else if (wr_acc)
        begin
            if (hit_option)
            begin
                resume_clears_wake_status_ff <= pwdata[`MRWF_BIT_RES_CLR];
            end
            if (hit_irq_mask)
            begin
                irq_mask_ff <= pwdata[3:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Destination address checks
    // ------------------------------------------------------------------
    assign cur_idx = rx_sof ? 7'h00 : byte_cnt_ff;
    assign in_da = (cur_idx < {4'h0, `MRWF_ADDR_BYTES});

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            byte_cnt_ff <= 7'h00;
            da_exact_ff <= 1'b0;
            da_bcast_ff <= 1'b0;
            da_unicast_ff <= 1'b0;
        end
        else if (ce && rx_valid)
        begin
            if (cur_idx != 7'h7F)
            begin
                byte_cnt_ff <= cur_idx + 7'h01;
            end
            if (in_da)
            begin
                da_exact_ff <= (rx_sof | da_exact_ff) &
                    (rx_data == addr_byte(station_addr, cur_idx[2:0]));
                da_bcast_ff <= (rx_sof | da_bcast_ff) &
                    (rx_data == `MRWF_BCAST_BYTE);
            end
            if (rx_sof)
            begin
                da_unicast_ff <= ~rx_data[0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Wake signature detector
    // ------------------------------------------------------------------
    // sync then sixteen addresses
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sig_state_ff <= MRWF_HUNT;
            ff_cnt_ff <= 3'h0;
            sig_byte_ff <= 3'h0;
            sig_rep_ff <= 4'h0;
            sig_found_ff <= 1'b0;
        end
        else if (ce && rx_valid)
        begin
            // A new frame always restarts the hunt for the sync bytes.
            if (rx_sof)
            begin
                sig_found_ff <= 1'b0;
                sig_state_ff <= MRWF_HUNT;
            end
            case (rx_sof ? MRWF_HUNT : sig_state_ff)
                MRWF_HUNT:
                begin
                    sig_byte_ff <= 3'h0;
                    sig_rep_ff <= 4'h0;
                    if (rx_data == `MRWF_BCAST_BYTE)
                    begin
                        if (ff_cnt_ff != `MRWF_SIG_SYNC && !rx_sof)
                        begin
                            ff_cnt_ff <= ff_cnt_ff + 3'h1;
                        end
                        else if (rx_sof)
                        begin
                            ff_cnt_ff <= 3'h1;
                        end
                    end
                    else if (!rx_sof && ff_cnt_ff == `MRWF_SIG_SYNC &&
                             rx_data == addr_byte(station_addr, 3'h0))
                    begin
                        sig_state_ff <= MRWF_ADDR;
                        sig_byte_ff <= 3'h1;
                        ff_cnt_ff <= 3'h0;
                    end
                    else
                    begin
                        ff_cnt_ff <= 3'h0;
                    end
                end
                MRWF_ADDR:
                begin
                    if (rx_data == addr_byte(station_addr, sig_byte_ff))
                    begin
                        if (sig_byte_ff == `MRWF_LAST_ADDR_BYTE)
                        begin
                            sig_byte_ff <= 3'h0;
                            sig_rep_ff <= sig_rep_ff + 4'h1;
                            if (sig_rep_ff == `MRWF_LAST_REPEAT)
                            begin
                                sig_found_ff <= 1'b1;
                                sig_state_ff <= MRWF_HUNT;
                            end
                        end
                        else
                        begin
                            sig_byte_ff <= sig_byte_ff + 3'h1;
                        end
                    end
                    else
                    begin
                        sig_state_ff <= MRWF_HUNT;
                        ff_cnt_ff <= (rx_data == `MRWF_BCAST_BYTE) ?
                                     3'h1 : 3'h0;
                    end
                end
                default:
                begin
                    sig_state_ff <= MRWF_HUNT;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Frame events and wake status
    // ------------------------------------------------------------------
    assign frame_end = ce & rx_valid & rx_eof & rx_frame_ok;

    always_comb
    begin
        events = 4'h0;
        events[3] = frame_end & exact_address_wake_enable_ff & da_exact_ff;
        events[2] = frame_end & filter_frame_wake_enable_ff &
                    (filter_hit |
                     (global_unicast_wake_enable_ff & da_unicast_ff));
        events[1] = frame_end & signature_packet_wake_enable_ff &
                    sig_found_ff;
        events[0] = frame_end & broadcast_wake_enable_ff & da_bcast_ff;
    end

    always_comb
    begin
        nxt_seen = seen_ff;
        if (wr_acc && hit_ctrl)
        begin
            nxt_seen = nxt_seen &
                ~pwdata[`MRWF_BIT_EXACT_SEEN:`MRWF_SEEN_LSB];
        end
        if (ce && resume_done && resume_clears_wake_status_ff)
        begin
            nxt_seen = 4'h0;
        end
        nxt_seen = nxt_seen | events;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            seen_ff <= 4'h0;
        end
        else
        begin
            seen_ff <= nxt_seen;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wake_req_ff <= 1'b0;
        end
        else if (ce)
        begin
            wake_req_ff <= |(seen_ff & enables);
        end
    end

    // ------------------------------------------------------------------
    // Interrupt
    // ------------------------------------------------------------------
    always_comb
    begin
        nxt_irq_stat = irq_stat_ff;
        if (rd_acc && hit_irq_stat)
        begin
            nxt_irq_stat = 4'h0;
        end
        nxt_irq_stat = nxt_irq_stat | events;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_stat_ff <= 4'h0;
            irq_ff <= 1'b0;
        end
        else if (ce)
        begin
            irq_stat_ff <= nxt_irq_stat;
            irq_ff <= |(irq_stat_ff & irq_mask_ff);
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign filt_rd_data = filt_rd_data_ff;
    assign wake_req = wake_req_ff;
    assign irq = irq_ff;

endmodule

//--- mrwf_frame_src.sv
/* Frame source standing on the receive side of the wakeup filter.
   Assumes the caller enters send right after a rising pclk edge. */
`timescale 1ns/1ps
module mrwf_frame_src (
    input wire logic pclk,
    output logic rx_valid,
    output logic rx_sof,
    output logic rx_eof,
    output logic [7:0] rx_data,
    output logic rx_frame_ok,
    output logic filter_hit
);
    initial
    begin
        rx_valid = 1'b0;
        rx_sof = 1'b0;
        rx_eof = 1'b0;
        rx_data = 8'h00;
        rx_frame_ok = 1'b0;
        filter_hit = 1'b0;
    end

    // Between frames the data lines show the inverse of the last byte.
    task automatic send(input logic [7:0] b[$], input logic ok, hit);
        for (int i = 0; i < b.size(); i++)
        begin
            rx_valid <= 1'b1;
            rx_sof <= (i == 0);
            rx_eof <= (i == b.size() - 1);
            rx_data <= b[i];
            rx_frame_ok <= ok;
            filter_hit <= hit;
            @(posedge pclk);
        end
        rx_valid <= 1'b0;
        rx_sof <= 1'b0;
        rx_eof <= 1'b0;
        rx_frame_ok <= 1'b0;
        filter_hit <= 1'b0;
        rx_data <= ~rx_data;
    endtask
endmodule

//--- mrwf_properties.sv
/* Port checker of the wakeup filter top module.
   Assumes one clock pclk and the async active-low reset presetn. */
`timescale 1ns/1ps
module mrwf_properties (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic rx_valid,
    input wire logic rx_eof,
    input wire logic rx_frame_ok,
    input wire logic resume_done,
    input wire logic wake_req,
    input wire logic irq
);
    wire logic acc = psel && penable && !pready && ce;
    wire logic fin = rx_valid && rx_eof && rx_frame_ok && ce;
    wire logic wr = psel && pwrite;

    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ------------------------------------------------------------
    // Bus timing and wake causes
    // ------------------------------------------------------------
    chk_ready_one_wait: assert property (acc |=> pready)
        else $error("pready not one cycle after access");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_ready_in_access: assert property (pready |-> psel && penable)
        else $error("pready outside an access");
    chk_ptr_bit_low: assert property
        (pready && !pwrite && paddr == 12'h12C |-> !prdata[31])
        else $error("pointer reset bit read back high");
    chk_wake_rise: assert property
        ($rose(wake_req) |-> $past(fin, 2) || $past(wr, 2))
        else $error("wake request rose without a cause");
    chk_wake_fall: assert property
        ($fell(wake_req) |-> $past(wr, 2) || $past(resume_done, 2))
        else $error("wake request fell without a clear");
    chk_irq_rise: assert property
        ($rose(irq) |-> $past(fin, 2) || $past(wr, 2))
        else $error("irq rose without a cause");
    chk_irq_fall: assert property ($fell(irq) |-> $past(psel, 2))
        else $error("irq fell without an access");
endmodule

bind mrwf_top mrwf_properties u_chk (.pclk, .presetn, .ce, .psel,
    .penable, .pwrite, .paddr, .prdata, .pready, .rx_valid, .rx_eof,
    .rx_frame_ok, .resume_done, .wake_req, .irq);

//--- test_mac_remote_wakeup_filter.sv
/* Bench of the wakeup filter: APB tasks, frame traffic, wake checks.
   Assumes the frame source model and the bound port checker. */
`timescale 1ns/1ps
`include "mrwf_regs.svh"
module test_mac_remote_wakeup_filter;
    logic pclk, presetn, psel, penable, pwrite, resume_done, ce;
    logic pready, pslverr, wake_req, irq, rd_e;
    logic rx_valid, rx_sof, rx_eof, rx_frame_ok, filter_hit;
    logic [7:0] rx_data;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, filt_rd_data, rd_v;
    logic [5:0] filt_rd_idx;
    logic [15:0] station_address_high = 16'h5544;
    logic [31:0] station_address_low = 32'h3322_1102;
    logic [7:0] q[$];
    int errors = 0;
    int check_count = 0;

    mrwf_top u_dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_valid, .rx_sof,
        .rx_eof, .rx_data, .rx_frame_ok, .filter_hit, .station_address_high,
        .station_address_low, .resume_done, .filt_rd_idx, .filt_rd_data,
        .wake_req, .irq);
    mrwf_frame_src u_src (.pclk, .rx_valid, .rx_sof, .rx_eof, .rx_data,
        .rx_frame_ok, .filter_hit);

    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic cw(input string n, input logic [31:0] e, g);
        check_count++;
        if (g !== e)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic cb(input string n, input logic e, g);
        cw(n, {31'h0, e}, {31'h0, g});
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rd_v = prdata;
        rd_e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50)
        begin
            errors++;
            end_sim();
        end
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input string n, input logic [11:0] a,
                      input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        cw(n, e, rd_v);
    endtask

    task automatic frame(input logic [47:0] da, input logic sig, ok, hit);
        logic [47:0] sa;
        sa = {station_address_high, station_address_low};
        q = {};
        for (int i = 0; i < 6; i++)
            q.push_back(da[8*i +: 8]);
        if (sig)
            repeat (16)
                for (int i = 0; i < 6; i++)
                    q.push_back(sa[8*i +: 8]);
        repeat (4)
            q.push_back(8'h00);
        u_src.send(q, ok, hit);
        repeat (3) @(posedge pclk);
    endtask

    task automatic ev(input logic [47:0] da, input logic sig, ok, hit,
                      input logic [3:0] s);
        frame(da, sig, ok, hit);
        rd("seen bits", `MRWF_OFF_CTRL, {24'h0, s, 4'hF});
        cb("wake", |s, wake_req);
        cb("irq", |s, irq);
        rd("irq status", `MRWF_OFF_IRQ_STAT, {28'h0, s});
        cb("irq cleared", 1'b0, irq);
        wr(`MRWF_OFF_CTRL, {24'h0, s, 4'hF});
        cb("wake cleared", 1'b0, wake_req);
        $display("event test %h done", s);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        resume_done = 1'b0;
        ce = 1'b1;
        filt_rd_idx = 6'h27;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        cw("memory reset", `MRWF_RST_WORD, filt_rd_data);
        rd("ctrl reset", `MRWF_OFF_CTRL, 32'h0);
        rd("mask reset", `MRWF_OFF_IRQ_MASK, 32'h0);
        rd("option reset", `MRWF_OFF_OPTION, 32'h0);
        for (int i = 0; i < 40; i++)
            wr(`MRWF_OFF_FILTER, 32'hC0DE_0000 + i);
        wr(`MRWF_OFF_FILTER, 32'hFFFF_0000);
        cw("last word", 32'hC0DE_0027, filt_rd_data);
        for (int i = 0; i < 41; i++)
            rd("window", `MRWF_OFF_FILTER, (i % 40 == 0) ? 32'hFFFF_0000 :
               32'hC0DE_0000 + i);
        wr(`MRWF_OFF_CTRL, 32'h8000_0000);
        rd("pointer bit", `MRWF_OFF_CTRL, 32'h0);
        rd("read restart", `MRWF_OFF_FILTER, 32'hFFFF_0000);
        wr(`MRWF_OFF_FILTER, 32'h1234_5678);
        filt_rd_idx <= 6'h00;
        repeat (2) @(posedge pclk);
        cw("write restart", 32'h1234_5678, filt_rd_data);
        filt_rd_idx <= 6'h3F;
        repeat (2) @(posedge pclk);
        cw("index range", 32'h0, filt_rd_data);
        $display("filter window test done");
        wr(`MRWF_OFF_IRQ_MASK, 32'hF);
        wr(`MRWF_OFF_CTRL, 32'hF);
        ev(48'hFFFF_FFFF_FFFF, 1'b0, 1'b1, 1'b0, 4'h1);
        ev(48'h5544_3322_1102, 1'b0, 1'b1, 1'b0, 4'h8);
        ev(48'h0000_0000_0A08, 1'b0, 1'b1, 1'b1, 4'h4);
        ev(48'hFFFF_FFFF_FFFF, 1'b1, 1'b1, 1'b0, 4'h3);
        ev(48'hFFFF_FFFF_FFFF, 1'b0, 1'b0, 1'b0, 4'h0);
        ce <= 1'b0;
        frame(48'hFFFF_FFFF_FFFF, 1'b0, 1'b1, 1'b0);
        ce <= 1'b1;
        rd("frozen seen", `MRWF_OFF_CTRL, 32'hF);
        cb("frozen wake", 1'b0, wake_req);
        $display("clock enable test done");
        wr(`MRWF_OFF_CTRL, 32'h204);
        frame(48'h0000_0000_0A08, 1'b0, 1'b1, 1'b0);
        rd("unicast seen", `MRWF_OFF_CTRL, 32'h244);
        cb("unicast wake", 1'b1, wake_req);
        wr(`MRWF_OFF_OPTION, 32'h1);
        resume_done <= 1'b1;
        @(posedge pclk);
        resume_done <= 1'b0;
        repeat (2) @(posedge pclk);
        rd("resume clear", `MRWF_OFF_CTRL, 32'h204);
        cb("resume wake", 1'b0, wake_req);
        $display("unicast and resume test done");
        rd("unmapped", 12'h100, 32'h0);
        cb("slverr", 1'b1, rd_e);
        $display("unmapped test done");
        end_sim();
    end
endmodule
